// file: inc/latency_table_pkg.sv
// constants for the sdr read latency lookup
package latency_table_pkg;
  localparam logic [7:0] NOT_SUPPORTED = 8'hff;
  localparam int ROW_COUNT = 6;
  localparam int ROW_LEN = 14;
  localparam int TABLE_BYTES = 88;
  localparam logic [7:0] PARAM_ID = 8'h90;
  localparam logic [7:0] PARAM_LEN = 8'h56;
  localparam logic [1:0] CODE_80 = 2'h0;
  localparam logic [1:0] CODE_90 = 2'h1;
  localparam logic [1:0] CODE_104 = 2'h2;
  localparam logic [1:0] CODE_50 = 2'h3;
  localparam logic [7:0] FREQ_80 = 8'h50;
  localparam logic [7:0] FREQ_90 = 8'h5a;
  localparam logic [7:0] FREQ_104 = 8'h68;
  localparam logic [7:0] FREQ_133 = 8'h85;
  // cycle counts handed back by the lookup, and what they read after reset
  localparam logic [7:0] CYCLES_RESET = 8'h00;
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] MODE_DIO = 8'h04;
  localparam logic [7:0] MODE_QIO = 8'h02;
  localparam logic [7:0] LAT_SLOW = 8'h00;
  localparam logic [7:0] LAT_FAST = 8'h08;
  localparam logic [7:0] LAT_DIO_50 = 8'h00;
  localparam logic [7:0] LAT_DIO_80 = 8'h00;
  localparam logic [7:0] LAT_DIO_90 = 8'h01;
  localparam logic [7:0] LAT_DIO_104 = 8'h02;
  localparam logic [7:0] LAT_QIO_50 = 8'h01;
  localparam logic [7:0] LAT_QIO_80 = 8'h04;
  localparam logic [7:0] LAT_QIO_90 = 8'h04;
  localparam logic [7:0] LAT_QIO_104 = 8'h05;
  localparam logic [7:0] OP_READ_3B = 8'h03;
  localparam logic [7:0] OP_READ_4B = 8'h13;
  localparam logic [7:0] OP_FAST_3B = 8'h0b;
  localparam logic [7:0] OP_FAST_4B = 8'h0c;
  localparam logic [7:0] OP_DOUT_3B = 8'h3b;
  localparam logic [7:0] OP_DOUT_4B = 8'h3c;
  localparam logic [7:0] OP_QOUT_3B = 8'h6b;
  localparam logic [7:0] OP_QOUT_4B = 8'h6c;
  localparam logic [7:0] OP_DIO_3B = 8'hbb;
  localparam logic [7:0] OP_DIO_4B = 8'hbc;
  localparam logic [7:0] OP_QIO_3B = 8'heb;
  localparam logic [7:0] OP_QIO_4B = 8'hec;
  typedef enum logic [2:0] {
    CMD_READ = 3'h0, CMD_FAST = 3'h1, CMD_DOUT = 3'h2,
    CMD_QOUT = 3'h3, CMD_DIO = 3'h4, CMD_QIO = 3'h5, CMD_NONE = 3'h7
  } read_cmd_t;
endpackage

// file: verilog/latency_code_table_rom.sv
// byte-addressed rom holding the sdr latency parameter block, registered read data
`timescale 1ns/1ps
module latency_code_table_rom
  import latency_table_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic [7:0] data_o
);
  // fewer address bits could not reach the last rows of the block
  if ((1 << ADDR_W) < TABLE_BYTES) begin : g_addr_check
    $error("rom address too narrow");
  end

  function automatic logic [7:0] rom_byte(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      7'h00: v = PARAM_ID;  7'h01: v = PARAM_LEN;
      7'h02: v = 8'h06;     7'h03: v = 8'h0e;
      7'h04: v = 8'h46;     7'h05: v = 8'h43;
      7'h06: v = OP_READ_3B; 7'h07: v = OP_READ_4B;
      7'h08: v = OP_FAST_3B; 7'h09: v = OP_FAST_4B;
      7'h0a: v = OP_DOUT_3B; 7'h0b: v = OP_DOUT_4B;
      7'h0c: v = OP_QOUT_3B; 7'h0d: v = OP_QOUT_4B;
      7'h0e: v = OP_DIO_3B;  7'h0f: v = OP_DIO_4B;
      7'h10: v = OP_QIO_3B;  7'h11: v = OP_QIO_4B;
      7'h12: v = 8'h32; 7'h13: v = {6'h00, CODE_50};
      7'h1c: v = 8'h04; 7'h1e: v = 8'h02; 7'h1f: v = 8'h01;
      7'h20: v = FREQ_80; 7'h21: v = {6'h00, CODE_80};
      7'h22, 7'h23: v = NOT_SUPPORTED;
      7'h25, 7'h27, 7'h29: v = 8'h08;
      7'h2a: v = 8'h04; 7'h2c: v = 8'h02; 7'h2d: v = 8'h04;
      7'h2e: v = FREQ_90; 7'h2f: v = {6'h00, CODE_90};
      7'h30, 7'h31: v = NOT_SUPPORTED;
      7'h33, 7'h35, 7'h37: v = 8'h08;
      7'h38: v = 8'h04; 7'h39: v = 8'h01; 7'h3a: v = 8'h02; 7'h3b: v = 8'h04;
      7'h3c: v = FREQ_104; 7'h3d: v = {6'h00, CODE_104};
      7'h3e, 7'h3f: v = NOT_SUPPORTED;
      7'h41, 7'h43, 7'h45: v = 8'h08;
      7'h46: v = 8'h04; 7'h47: v = 8'h02; 7'h48: v = 8'h02; 7'h49: v = 8'h05;
      7'h4a: v = FREQ_133; 7'h4b: v = {6'h00, CODE_104};
      7'h4c, 7'h4d: v = NOT_SUPPORTED;
      7'h4f: v = 8'h08;
      7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57: v = NOT_SUPPORTED;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= 8'h00;
    end else begin
      // bytes past the block read as zero, also on a wider address bus
      data_o <= (addr_i < ADDR_W'(TABLE_BYTES)) ? rom_byte(7'(addr_i)) : 8'h00;
    end
  end
endmodule

// file: verilog/sdr_read_latency_table.sv
// sdr read latency lookup: parameter bytes and decoded mode/latency per opcode and code
`timescale 1ns/1ps
module sdr_read_latency_table
  import latency_table_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] table_addr_i,
  output logic [7:0] table_data_o,
  input wire logic lookup_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [1:0] latency_code_i,
  input wire logic high_freq_i,
  output logic lookup_done_o,
  output logic [7:0] mode_cycles_o,
  output logic [7:0] latency_cycles_o,
  output logic supported_o
);
  read_cmd_t cmd;
  logic [7:0] mode_next;
  logic [7:0] lat_next;

  // one entry per table row after the opcode row; rows five and six share code 10b
  typedef enum logic [2:0] {
    ROW_50 = 3'h0,
    ROW_80 = 3'h1,
    ROW_90 = 3'h2,
    ROW_104 = 3'h3,
    ROW_133 = 3'h4
  } table_row_t;
  table_row_t row_sel;

  // fewer address bits could not reach the last rows of the parameter block
  if ((1 << ADDR_W) < TABLE_BYTES) begin : g_addr_check
    $error("table address too narrow for the parameter block");
  end

  latency_code_table_rom #(.ADDR_W(ADDR_W)) rom_u (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(table_addr_i),
    .data_o(table_data_o)
  );

  always_comb begin
    unique case (opcode_i)
      OP_READ_3B, OP_READ_4B: cmd = CMD_READ;
      OP_FAST_3B, OP_FAST_4B: cmd = CMD_FAST;
      OP_DOUT_3B, OP_DOUT_4B: cmd = CMD_DOUT;
      OP_QOUT_3B, OP_QOUT_4B: cmd = CMD_QOUT;
      OP_DIO_3B, OP_DIO_4B: cmd = CMD_DIO;
      OP_QIO_3B, OP_QIO_4B: cmd = CMD_QIO;
      default: cmd = CMD_NONE;
    endcase
  end

  always_comb begin
    row_sel = ROW_50;
    unique case (latency_code_i)
      CODE_50: row_sel = ROW_50;
      CODE_80: row_sel = ROW_80;
      CODE_90: row_sel = ROW_90;
      CODE_104: begin
        // the code alone cannot tell 104 from 133 MHz; the host knows its clock
        if (high_freq_i) begin
          row_sel = ROW_133;
        end else begin
          row_sel = ROW_104;
        end
      end
    endcase
  end

  // every entry starts unsupported, so a command left out of a row reads as ffh
  always_comb begin
    mode_next = NOT_SUPPORTED;
    lat_next = NOT_SUPPORTED;
    unique case (row_sel)
      ROW_50: begin
        unique case (cmd)
          CMD_READ: begin
            mode_next = MODE_NONE;
            lat_next = LAT_SLOW;
          end
          CMD_FAST: begin
            mode_next = MODE_NONE;
            lat_next = LAT_SLOW;
          end
          CMD_DOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_SLOW;
          end
          CMD_QOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_SLOW;
          end
          CMD_DIO: begin
            mode_next = MODE_DIO;
            lat_next = LAT_DIO_50;
          end
          CMD_QIO: begin
            mode_next = MODE_QIO;
            lat_next = LAT_QIO_50;
          end
          default: ;
        endcase
      end
      ROW_80: begin
        unique case (cmd)
          CMD_READ: ;
          CMD_FAST: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_QOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DIO: begin
            mode_next = MODE_DIO;
            lat_next = LAT_DIO_80;
          end
          CMD_QIO: begin
            mode_next = MODE_QIO;
            lat_next = LAT_QIO_80;
          end
          default: ;
        endcase
      end
      ROW_90: begin
        unique case (cmd)
          CMD_READ: ;
          CMD_FAST: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_QOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DIO: begin
            mode_next = MODE_DIO;
            lat_next = LAT_DIO_90;
          end
          CMD_QIO: begin
            mode_next = MODE_QIO;
            lat_next = LAT_QIO_90;
          end
          default: ;
        endcase
      end
      ROW_104: begin
        unique case (cmd)
          CMD_READ: ;
          CMD_FAST: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_QOUT: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          CMD_DIO: begin
            mode_next = MODE_DIO;
            lat_next = LAT_DIO_104;
          end
          CMD_QIO: begin
            mode_next = MODE_QIO;
            lat_next = LAT_QIO_104;
          end
          default: ;
        endcase
      end
      ROW_133: begin
        unique case (cmd)
          CMD_FAST: begin
            mode_next = MODE_NONE;
            lat_next = LAT_FAST;
          end
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lookup_done_o <= 1'b0;
    end else begin
      lookup_done_o <= lookup_valid_i;
    end
  end

  // answers stand until the next request, so a slow host may read them late
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_cycles_o <= CYCLES_RESET;
      latency_cycles_o <= CYCLES_RESET;
    end else if (lookup_valid_i) begin
      mode_cycles_o <= mode_next;
      latency_cycles_o <= lat_next;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supported_o <= 1'b0;
    end else if (lookup_valid_i) begin
      supported_o <= (mode_next != NOT_SUPPORTED) && (lat_next != NOT_SUPPORTED);
    end
  end
endmodule

// file: verif/sdr_read_latency_table_chk.sv
// assertions on the sdr read latency lookup ports
`timescale 1ns/1ps
module sdr_read_latency_table_chk
  import latency_table_pkg::*;
#(parameter int ADDR_W = 7) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] table_addr_i,
  input wire logic [7:0] table_data_o,
  input wire logic lookup_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [1:0] latency_code_i,
  input wire logic high_freq_i,
  input wire logic lookup_done_o,
  input wire logic [7:0] mode_cycles_o,
  input wire logic [7:0] latency_cycles_o,
  input wire logic supported_o
);
  wire v = lookup_valid_i;
  wire [7:0] op = opcode_i;
  wire [1:0] c = latency_code_i;
  wire [7:0] m = mode_cycles_o;
  wire [7:0] l = latency_cycles_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_fast; v && op == OP_FAST_4B && c != CODE_50 |=> m == 8'h00 && l == 8'h08; endproperty
  a_fast: assert property (p_fast) else $error("fast");
  property p_read; v && op == OP_READ_3B && c != CODE_50 |=> !supported_o && m == 8'hff; endproperty
  a_read: assert property (p_read) else $error("read");
  property p_r3; v && op == OP_DIO_3B && c == CODE_80 |=> m == 8'h04 && l == 8'h00; endproperty
  a_r3: assert property (p_r3) else $error("dio 80");
  property p_r4; v && op == OP_DIO_4B && c == CODE_90 |=> m == 8'h04 && l == 8'h01; endproperty
  a_r4: assert property (p_r4) else $error("dio 90");
  property p_r5; v && op == OP_QIO_3B && c == CODE_104 && !high_freq_i |=> l == 8'h05; endproperty
  a_r5: assert property (p_r5) else $error("qio 104");
  property p_r6; v && op == OP_DOUT_3B && c == CODE_104 && high_freq_i |=> l == 8'hff; endproperty
  a_r6: assert property (p_r6) else $error("dout 133");
  property p_ff; lookup_done_o && m == 8'hff |-> !supported_o; endproperty
  a_ff: assert property (p_ff) else $error("ff entry");
  property p_rom; table_addr_i == 7'h3d |=> table_data_o == 8'h02; endproperty
  a_rom: assert property (p_rom) else $error("rom code");
endmodule
bind sdr_read_latency_table sdr_read_latency_table_chk #(.ADDR_W(ADDR_W)) chk_u (.clock_i,
  .reset_n_i, .table_addr_i, .table_data_o, .lookup_valid_i, .opcode_i, .latency_code_i,
  .high_freq_i, .lookup_done_o, .mode_cycles_o, .latency_cycles_o, .supported_o);

// file: verif/read_host_model.sv
// host side: picks the code whose ceiling covers its clock and issues lookups
`timescale 1ns/1ps
module read_host_model
  import latency_table_pkg::*;
(
  input wire logic go_i,
  input wire logic [7:0] freq_i,
  input wire logic [7:0] op_i,
  output logic valid_o,
  output logic [7:0] opcode_o,
  output logic [1:0] code_o,
  output logic high_o
);
  always_comb begin
    valid_o = go_i;
    opcode_o = op_i;
    high_o = freq_i > FREQ_104;
    if (freq_i <= 8'h32) code_o = CODE_50;
    else if (freq_i <= FREQ_80) code_o = CODE_80;
    else if (freq_i <= FREQ_90) code_o = CODE_90;
    else code_o = CODE_104;
  end
endmodule

// file: verif/tb_sdr_read_latency_table.sv
// self-checking bench for the sdr read latency lookup
`timescale 1ns/1ps
module tb_sdr_read_latency_table import latency_table_pkg::*;;
  logic clock_i = 0, reset_n_i = 0, go = 0, vld, hf, done, sup;
  logic [6:0] ta = '0;
  logic [7:0] fq = 8'h50, op = '0, td, opc, mc, lc;
  logic [1:0] code;
  int failures = 0, samples_checked = 0, cyc = 0, i;
  logic [31:0] rows [26] = '{32'h5003ffff, 32'h500c0008, 32'h503b0008, 32'h506b0008,
    32'h50bb0400, 32'h50ec0204, 32'h5abc0401, 32'h5aeb0204, 32'h5a13ffff, 32'h5a6c0008,
    32'h68eb0205, 32'h68bb0402, 32'h6803ffff, 32'h683c0008, 32'h850c0008, 32'h853bffff,
    32'h856bffff, 32'h85bcffff, 32'h85ecffff, 32'h8503ffff, 32'h5000ffff, 32'h5a00ffff,
    32'h32030000, 32'h32bb0400, 32'h32ec0201, 32'h326b0000};
  logic [15:0] rom [8] = '{16'h0090, 16'h0156, 16'h0206, 16'h2e5a, 16'h2f01, 16'h3d02,
    16'h4a85, 16'h57ff};
  read_host_model host_u (.go_i(go), .freq_i(fq), .op_i(op), .valid_o(vld),
    .opcode_o(opc), .code_o(code), .high_o(hf));
  sdr_read_latency_table dut_u (.clock_i, .reset_n_i, .table_addr_i(ta), .table_data_o(td),
    .lookup_valid_i(vld), .opcode_i(opc), .latency_code_i(code), .high_freq_i(hf),
    .lookup_done_o(done), .mode_cycles_o(mc), .latency_cycles_o(lc), .supported_o(sup));
  initial forever #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 200) begin
      failures++;
      summarize();
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task summarize;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock_i);
    reset_n_i = 1;
    // back-to-back lookups: check the previous row while issuing the next
    for (i = 0; i <= 26; i++) begin
      @(negedge clock_i);
      if (i > 0) begin
        chk({7'h0, done}, 8'h01);
        chk(mc, rows[i-1][15:8]);
        chk(lc, rows[i-1][7:0]);
        chk({7'h0, sup}, {7'h0, rows[i-1][7:0] != 8'hff});
        chk(td, rom[(i-1)%8][7:0]);
      end
      if (i < 26) {fq, op} = rows[i][31:16];
      go = (i < 26);
      ta = rom[i%8][14:8];
    end
    @(negedge clock_i);
    chk({7'h0, done}, 8'h00);
    {fq, op, go} = {16'h85bb, 1'b1};
    @(negedge clock_i);
    reset_n_i = 0;
    @(negedge clock_i);
    chk(mc | lc | {7'h0, done}, 8'h00);
    chk({7'h0, sup}, 8'h00);
    // the request held through reset is taken at the first edge after release
    reset_n_i = 1;
    @(negedge clock_i);
    chk({7'h0, done}, 8'h01);
    chk(mc, 8'hff);
    chk({7'h0, sup}, 8'h00);
    summarize();
  end
endmodule
